// ---- hbus_pkg.sv ----
// Shared constants, types and decode helpers for the halfword burst bus
`default_nettype none
package hbus_pkg;
    // ------------------------------------------------------------------
    // Bus geometry and sequencing constants
    // ------------------------------------------------------------------
    localparam logic [2:0] FILL_LAST = 3'h7;
    localparam logic [3:0] BE_ALL_N = 4'h0;
    localparam logic [3:0] BE_HIGH_HALF_N = 4'h3;
    localparam int REQ_W = 30 + 4 + 4 + 32;

    // Device end sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10
    } dev_state_type;

    // Far end responder states
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_REQ  = 2'b01,
        HS_ACK  = 2'b10
    } host_state_type;

    // Even parity bit per byte lane: the byte plus its bit hold even ones
    function automatic logic [1:0] lane_parity(input logic [15:0] d);
        lane_parity = {^d[15:8], ^d[7:0]};
    endfunction

    // Word select, upper and lower enable from active-low lane enables
    function automatic logic [2:0] be_decode(input logic [3:0] be_n);
        logic ws;
        ws = be_n[0] & be_n[1];
        be_decode = {ws, (ws ? be_n[3] : be_n[1]), (ws ? be_n[2] : be_n[0])};
    endfunction

    // True when enabled bytes sit in both halfwords of the word
    function automatic logic spans_two(input logic [3:0] be_n);
        spans_two = (be_n[1:0] != 2'b11) && (be_n[3:2] != 2'b11);
    endfunction
endpackage
`default_nettype wire

// ---- hbus_if.sv ----
// Bus wires between the processor end and the memory/I/O controller end
`timescale 1ns/1ns
`default_nettype none
interface hbus_if;
    logic [31:2] word_address_lines;
    logic [3:0] byte_lane_enables_n;
    logic cycle_start_strobe_n;
    logic final_transfer_indicator_n;
    logic write_not_read;
    logic mem_not_io;
    logic data_not_code;
    logic [15:0] dev_data_lines;
    logic [1:0] dev_lane_parity;
    logic dev_data_oe;
    logic [15:0] host_data_lines;
    logic [1:0] host_lane_parity;
    logic host_data_oe;
    logic data_ack_n;
    logic cacheable_n;
    logic hold_req;
    logic hold_ack;

    modport device (
        output word_address_lines, byte_lane_enables_n, cycle_start_strobe_n,
        output final_transfer_indicator_n, write_not_read, mem_not_io,
        output data_not_code, dev_data_lines, dev_lane_parity, dev_data_oe,
        output hold_ack,
        input host_data_lines, host_lane_parity, host_data_oe, data_ack_n,
        input cacheable_n, hold_req
    );
    modport host (
        input word_address_lines, byte_lane_enables_n, cycle_start_strobe_n,
        input final_transfer_indicator_n, write_not_read, mem_not_io,
        input data_not_code, dev_data_lines, dev_lane_parity, dev_data_oe,
        input hold_ack,
        output host_data_lines, host_lane_parity, host_data_oe, data_ack_n,
        output cacheable_n, hold_req
    );
endinterface
`default_nettype wire

// ---- req_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("req_fifo needs a power-of-two depth of at least 2");
        end
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Flags from the fill count
    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_data_out = mem_r[rd_ptr_r];

    // Write side
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    // Pointer and count bookkeeping
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push != pop) begin
                count_r <= push ? count_r + 1'b1 : count_r - 1'b1;
            end
        end
    end
endmodule // req_fifo
`default_nettype wire

// ---- hbus_device.sv ----
// Processor end of the halfword bus: splitting, bursts and line fills
`timescale 1ns/1ns
`default_nettype none
module hbus_device #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    hbus_if.device bus,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [31:0] req_addr_in,
    input wire logic [3:0] req_be_n_in,
    input wire logic req_write_in,
    input wire logic req_mem_in,
    input wire logic req_code_in,
    input wire logic req_burst_in,
    input wire logic [31:0] req_wdata_in,
    input wire logic stop_fill_in,
    output logic [15:0] rdata_out,
    output logic [3:1] raddr_out,
    output logic rvalid_out,
    output logic parity_err_out,
    output logic done_out,
    output logic busy_out
);
    import hbus_pkg::*;

    // ------------------------------------------------------------------
    // Request queue
    // ------------------------------------------------------------------
    logic q_valid;
    logic q_ready;
    logic [REQ_W-1:0] q_data;
    logic [REQ_W-1:0] in_pack;

    // Packet: word address, enables, flags, write data
    assign in_pack = {req_addr_in[31:2], req_be_n_in, req_write_in,
                      req_mem_in, req_code_in, req_burst_in, req_wdata_in};

    req_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_queue (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .in_valid_in(req_valid_in),
        .in_ready_out(req_ready_out),
        .in_data_in(in_pack),
        .out_valid_out(q_valid),
        .out_ready_in(q_ready),
        .out_data_out(q_data)
    );

    // ------------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------------
    dev_state_type state_r;
    logic [31:2] addr_r;
    logic [3:0] be_r;
    logic wr_r;
    logic mem_r;
    logic code_r;
    logic burst_r;
    logic [31:0] wdata_r;
    logic [2:0] cnt_r;
    logic two_r;
    logic fill_r;
    logic stop_r;
    logic hold_ack_r;
    logic [15:0] dout_r;
    logic ack;
    logic last;
    logic start_fill;
    logic [1:0] quad;

    // Pop only when idle and not held
    assign q_ready = (state_r == ST_IDLE) && !hold_ack_r && !bus.hold_req;
    assign ack = (state_r == ST_DATA) && !bus.data_ack_n;
    // Fill on cacheable data read or code fetch
    assign start_fill = !wr_r && mem_r && (code_r || !bus.cacheable_n);

    // Last data cycle of the current transfer
    always_comb begin
        if (fill_r) begin
            last = (cnt_r == FILL_LAST) || stop_r || stop_fill_in;
        end else begin
            last = !two_r || (cnt_r[0] == 1'b1);
        end
    end

    // Main sequencer
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (q_valid && q_ready) begin
                        state_r <= ST_START;
                        cnt_r <= 3'h0;
                    end
                end
                ST_START: begin
                    state_r <= ST_DATA;
                end
                ST_DATA: begin
                    if (ack) begin
                        cnt_r <= cnt_r + 3'h1;
                        if (last) begin
                            state_r <= ST_IDLE;
                        end else if (!fill_r && !burst_r) begin
                            // Unburst remainder opens with its own strobe
                            state_r <= ST_START;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Request capture, held to the end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_r <= '0;
            be_r <= 4'hF;
            wr_r <= 1'b0;
            mem_r <= 1'b0;
            code_r <= 1'b0;
            burst_r <= 1'b0;
            wdata_r <= '0;
            two_r <= 1'b0;
        end else if (q_valid && q_ready) begin
            {addr_r, be_r, wr_r, mem_r, code_r, burst_r, wdata_r} <= q_data;
            two_r <= spans_two(q_data[39:36]);
        end
    end

    // Fill decided at strobe; early stop kept
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fill_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (state_r == ST_START && cnt_r == 3'h0) begin
            fill_r <= start_fill;
            stop_r <= 1'b0;
        end else if (fill_r && stop_fill_in) begin
            stop_r <= 1'b1;
        end
    end

    // Write half: enabled half, no lane copies
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dout_r <= '0;
        end else if (q_valid && q_ready) begin
            dout_r <= (q_data[37:36] == 2'b11) ? q_data[31:16]
                                               : q_data[15:0];
        end else if (ack && !last) begin
            dout_r <= wdata_r[31:16];
        end
    end

    // Hold granted only between transfers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_ack_r <= 1'b0;
        end else begin
            hold_ack_r <= bus.hold_req && (state_r == ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------------
    // Fill quad walks start ^ {0,1,2,3}, giving the interleaved order
    assign quad = addr_r[3:2] ^ cnt_r[2:1];
    assign bus.word_address_lines = fill_r ? {addr_r[31:4], quad}
                                           : addr_r;

    // Enables: fill alternates 0000/0011; second half keeps upper bits
    always_comb begin
        if (fill_r) begin
            bus.byte_lane_enables_n = cnt_r[0] ? BE_HIGH_HALF_N
                                               : BE_ALL_N;
        end else if (cnt_r[0]) begin
            bus.byte_lane_enables_n = be_r | BE_HIGH_HALF_N;
        end else begin
            bus.byte_lane_enables_n = be_r;
        end
    end

    assign bus.cycle_start_strobe_n = (state_r != ST_START);
    // Burst continues while the indicator stays high
    assign bus.final_transfer_indicator_n = (state_r == ST_DATA) &&
        !last && (fill_r || burst_r);
    assign bus.write_not_read = wr_r;
    assign bus.mem_not_io = mem_r;
    assign bus.data_not_code = !code_r;
    assign bus.dev_data_lines = dout_r;
    assign bus.dev_lane_parity = lane_parity(dout_r);
    // Released on reads and while the bus is handed over
    assign bus.dev_data_oe = wr_r && (state_r != ST_IDLE)
                             && !hold_ack_r;
    assign bus.hold_ack = hold_ack_r;

    // ------------------------------------------------------------------
    // Read return and completion
    // ------------------------------------------------------------------
    // Read half out with position and parity check
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= '0;
            raddr_out <= 3'h0;
            rvalid_out <= 1'b0;
            parity_err_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            rvalid_out <= ack && !wr_r;
            parity_err_out <= ack && !wr_r && (bus.host_lane_parity !=
                lane_parity(bus.host_data_lines));
            done_out <= ack && last;
            if (ack && !wr_r) begin
                rdata_out <= bus.host_data_lines;
                raddr_out <= {bus.word_address_lines[3:2],
                    &bus.byte_lane_enables_n[1:0]};
            end
        end
    end

    assign busy_out = (state_r != ST_IDLE) || q_valid;
endmodule // hbus_device
`default_nettype wire

// ---- hbus_host.sv ----
// Memory and I/O controller end: lane decode and data cycle answers
`timescale 1ns/1ns
`default_nettype none
module hbus_host (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    hbus_if.host bus,
    input wire logic cacheable_in,
    input wire logic hold_in,
    output logic hold_granted_out,
    output logic mem_valid_out,
    input wire logic mem_ready_in,
    output logic [31:0] mem_addr_out,
    output logic mem_upper_n_out,
    output logic mem_lower_n_out,
    output logic mem_write_out,
    output logic mem_io_out,
    output logic [15:0] mem_wdata_out,
    input wire logic [15:0] mem_rdata_in
);
    import hbus_pkg::*;

    // ------------------------------------------------------------------
    // Data cycle responder
    // ------------------------------------------------------------------
    host_state_type state_r;
    logic first_fill_r;
    logic cache_n_r;
    logic hold_r;
    logic [15:0] rdata_r;
    logic [2:0] dec;

    // One memory access, then a one-cycle ack
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= HS_IDLE;
            first_fill_r <= 1'b0;
        end else begin
            case (state_r)
                HS_IDLE: begin
                    if (!bus.cycle_start_strobe_n) begin
                        state_r <= HS_REQ;
                        first_fill_r <= !bus.write_not_read && bus.mem_not_io
                            && (!bus.data_not_code || !cache_n_r);
                    end
                end
                HS_REQ: begin
                    if (mem_ready_in) begin
                        state_r <= HS_ACK;
                    end
                end
                HS_ACK: begin
                    first_fill_r <= 1'b0;
                    // High indicator means the burst goes on
                    state_r <= bus.final_transfer_indicator_n ? HS_REQ
                                                              : HS_IDLE;
                end
                default: begin
                    state_r <= HS_IDLE;
                end
            endcase
        end
    end

    // Read data held for the ack cycle
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_r <= '0;
        end else if (state_r == HS_REQ && mem_ready_in) begin
            rdata_r <= mem_rdata_in;
        end
    end

    // Cacheable and hold levels
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cache_n_r <= 1'b1;
            hold_r <= 1'b0;
        end else begin
            cache_n_r <= !cacheable_in;
            hold_r <= hold_in;
        end
    end

    // ------------------------------------------------------------------
    // Lane decode and outputs
    // ------------------------------------------------------------------
    // First fill cycle: enables ignored, quad start
    assign dec = first_fill_r ? 3'b000
                              : be_decode(bus.byte_lane_enables_n);

    assign mem_valid_out = (state_r == HS_REQ);
    assign mem_addr_out = {bus.word_address_lines, dec[2], 1'b0};
    assign mem_upper_n_out = dec[1];
    assign mem_lower_n_out = dec[0];
    assign mem_write_out = bus.write_not_read;
    assign mem_io_out = !bus.mem_not_io;
    assign mem_wdata_out = bus.dev_data_lines;
    assign hold_granted_out = bus.hold_ack;

    assign bus.host_data_lines = rdata_r;
    assign bus.host_lane_parity = lane_parity(rdata_r);
    assign bus.host_data_oe = (state_r == HS_ACK) && !bus.write_not_read;
    assign bus.data_ack_n = (state_r != HS_ACK);
    assign bus.cacheable_n = cache_n_r;
    assign bus.hold_req = hold_r;
endmodule // hbus_host
`default_nettype wire

// ---- hbus_assertions.sv ----
// Concurrent checks on the wires between both ends of the halfword bus
`timescale 1ns/1ns
`default_nettype none
module hbus_checker (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [31:2] word_address_lines,
    input wire logic [3:0] byte_lane_enables_n,
    input wire logic cycle_start_strobe_n,
    input wire logic final_transfer_indicator_n,
    input wire logic write_not_read,
    input wire logic mem_not_io,
    input wire logic data_not_code,
    input wire logic [15:0] dev_data_lines,
    input wire logic [1:0] dev_lane_parity,
    input wire logic dev_data_oe,
    input wire logic data_ack_n,
    input wire logic hold_ack
);
    import hbus_pkg::*;
    // ------------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------------
    logic [31:4] upper_address_lines;
    logic [3:2] quad_sel;
    logic [2:0] selects;
    logic mid_ack;
    // Slices as nets for $past
    assign upper_address_lines = word_address_lines[31:4];
    assign quad_sel = word_address_lines[3:2];
    assign selects = {write_not_read, mem_not_io, data_not_code};
    assign mid_ack = !data_ack_n && final_transfer_indicator_n;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    a_read_no_drive: assert property (dev_data_oe |-> write_not_read)
        else $error("data driven on read");
    a_hold_quiet: assert property (hold_ack |-> !dev_data_oe)
        else $error("data driven in hold");
    a_write_parity: assert property (dev_data_oe |-> dev_lane_parity ==
        {^dev_data_lines[15:8], ^dev_data_lines[7:0]})
        else $error("write parity");
    a_strobe_answer: assert property (!cycle_start_strobe_n |=>
        cycle_start_strobe_n ##[0:80] !data_ack_n)
        else $error("strobe unanswered");
    a_half_step: assert property (mid_ack &&
        byte_lane_enables_n == BE_ALL_N |=> byte_lane_enables_n ==
        BE_HIGH_HALF_N && word_address_lines == $past(word_address_lines))
        else $error("burst half");
    a_quad_step: assert property (mid_ack &&
        byte_lane_enables_n == BE_HIGH_HALF_N |=> byte_lane_enables_n ==
        BE_ALL_N && upper_address_lines == $past(upper_address_lines) &&
        quad_sel != $past(quad_sel))
        else $error("quad step");
    a_selects_held: assert property (mid_ack |=> $stable(selects))
        else $error("selects moved");
    // An unburst first half still has its remainder pending
    a_last_gap: assert property (!data_ack_n &&
        !final_transfer_indicator_n && !spans_two(byte_lane_enables_n)
        |=> cycle_start_strobe_n)
        else $error("strobe after last");
    c_fill_end: cover property (mid_ack && !write_not_read && quad_sel != 0);
    c_burst_write: cover property (mid_ack && write_not_read);
    c_hold: cover property (hold_ack);
endmodule // hbus_checker
`default_nettype wire

// ---- test_halfword_bus_burst_interface.sv ----
// Self-checking bench joining both ends of the halfword bus
`timescale 1ns/1ns
`default_nettype none
module test_halfword_bus_burst_interface;
    logic clk_sys_in = 1'b0, nrst_in = 1'b0, stop_fill_in = 1'b0;
    logic req_valid_in = 1'b0, req_write_in = 1'b0, req_mem_in = 1'b0;
    logic req_code_in = 1'b0, req_burst_in = 1'b0, cacheable_in = 1'b0;
    logic hold_in = 1'b0, mem_ready_in = 1'b0;
    logic [31:0] req_addr_in = 32'h0, req_wdata_in = 32'h0, mem_addr_out;
    logic [3:0] req_be_n_in = 4'hF;
    logic [15:0] rdata_out, mem_wdata_out, mem_rdata_in;
    logic [3:1] raddr_out;
    logic req_ready_out, rvalid_out, parity_err_out, done_out, busy_out;
    logic hold_granted_out, mem_valid_out, mem_upper_n_out, mem_lower_n_out;
    logic mem_write_out, mem_io_out;
    logic [31:0] cap_a[$];
    logic [3:0] cap_l[$];
    logic [15:0] cap_d[$];
    logic [18:0] rd_q[$];
    int miscompares = 0, total_checks = 0, strobes = 0, dones = 0;
    int perr = 0, cycles = 0, wait_cnt = 0, mem_delay = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    // Memory byte = its address low byte
    assign mem_rdata_in = {mem_addr_out[7:0] + 8'h01, mem_addr_out[7:0]};
    hbus_if hbus_if_inst ();
    hbus_device #(.FIFO_DEPTH(4)) hbus_device_inst (.clk_sys_in, .nrst_in,
        .bus(hbus_if_inst), .req_valid_in, .req_ready_out, .req_addr_in,
        .req_be_n_in, .req_write_in, .req_mem_in, .req_code_in,
        .req_burst_in, .req_wdata_in, .stop_fill_in, .rdata_out, .raddr_out,
        .rvalid_out, .parity_err_out, .done_out, .busy_out);
    hbus_host hbus_host_inst (.clk_sys_in, .nrst_in, .bus(hbus_if_inst),
        .cacheable_in, .hold_in, .hold_granted_out, .mem_valid_out,
        .mem_ready_in, .mem_addr_out, .mem_upper_n_out, .mem_lower_n_out,
        .mem_write_out, .mem_io_out, .mem_wdata_out, .mem_rdata_in);
    hbus_checker hbus_checker_inst (.clk_sys_in, .nrst_in,
        .word_address_lines(hbus_if_inst.word_address_lines),
        .byte_lane_enables_n(hbus_if_inst.byte_lane_enables_n),
        .cycle_start_strobe_n(hbus_if_inst.cycle_start_strobe_n),
        .final_transfer_indicator_n(hbus_if_inst.final_transfer_indicator_n),
        .write_not_read(hbus_if_inst.write_not_read),
        .mem_not_io(hbus_if_inst.mem_not_io),
        .data_not_code(hbus_if_inst.data_not_code),
        .dev_data_lines(hbus_if_inst.dev_data_lines),
        .dev_lane_parity(hbus_if_inst.dev_lane_parity),
        .dev_data_oe(hbus_if_inst.dev_data_oe),
        .data_ack_n(hbus_if_inst.data_ack_n),
        .hold_ack(hbus_if_inst.hold_ack));
    // Memory answers after mem_delay waits
    always @(negedge clk_sys_in) begin
        wait_cnt <= (mem_valid_out && !mem_ready_in) ? wait_cnt + 1 : 0;
        mem_ready_in <= mem_valid_out && !mem_ready_in && wait_cnt >= mem_delay;
    end
    // Beat, strobe and return monitor; watchdog
    always @(posedge clk_sys_in) begin
        if (mem_valid_out && mem_ready_in) begin
            cap_a.push_back(mem_addr_out);
            cap_l.push_back({mem_upper_n_out, mem_lower_n_out, mem_write_out,
                mem_io_out});
            cap_d.push_back(mem_wdata_out);
        end
        strobes += (hbus_if_inst.cycle_start_strobe_n === 1'b0);
        if (rvalid_out === 1'b1) rd_q.push_back({raddr_out, rdata_out});
        perr += (rvalid_out === 1'b1 && parity_err_out !== 1'b0);
        dones += (done_out === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic check_val(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clr();
        cap_a.delete();
        cap_l.delete();
        cap_d.delete();
        rd_q.delete();
        strobes = 0;
        dones = 0;
    endtask
    // Request held until ready is seen
    task automatic send(input logic [31:0] a, input logic [3:0] be,
        input logic [3:0] f, input logic [31:0] wd);
        @(negedge clk_sys_in);
        req_valid_in = 1'b1;
        req_addr_in = a;
        req_be_n_in = be;
        {req_write_in, req_mem_in, req_code_in, req_burst_in} = f;
        req_wdata_in = wd;
        do @(posedge clk_sys_in); while (req_ready_out !== 1'b1);
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
    endtask
    task automatic wait_done(input int n);
        for (int i = 0; i < 400 && dones < n; i++) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check_val("done count", n, dones);
    endtask
    task automatic t_write();
        clr();
        send(32'h100, 4'hC, 4'b1100, 32'hDDCCBBAA);
        wait_done(1);
        check_val("write addr", 32'h100, cap_a[0]);
        check_val("write lanes", 4'b0010, cap_l[0]);
        check_val("write data", 16'hBBAA, cap_d[0]);
        clr();
        send(32'h104, 4'hD, 4'b1100, 32'h0000BB00);
        wait_done(1);
        check_val("high byte", 8'hBB, cap_d[0][15:8]);
        check_val("high lanes", 4'b0110, cap_l[0]);
        for (int b = 0; b < 2; b++) begin
            clr();
            send(32'h204, 4'h0, {3'b110, b[0]}, 32'h44332211);
            wait_done(1);
            check_val("strobes", 2 - b, strobes);
            check_val("half addr", 32'h206, cap_a[1]);
            check_val("split data", 32'h44332211, {cap_d[1], cap_d[0]});
        end
    endtask
    // Each contiguous enable pattern as an I/O read
    task automatic t_patterns();
        logic [3:0] pat [10];
        logic [2:0] dec [10];
        int n;
        pat = '{4'hE, 4'hC, 4'h8, 4'h0, 4'hD, 4'h9, 4'h1, 4'hB, 4'h3, 4'h7};
        dec = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h6, 3'h4, 3'h5};
        for (int i = 0; i < 10; i++) begin
            clr();
            n = (pat[i][1:0] != 2'b11 && pat[i][3:2] != 2'b11) ? 2 : 1;
            send(32'h400, pat[i], 4'b0000, 32'h0);
            wait_done(1);
            check_val("cycles", n, cap_a.size());
            check_val("decode", {dec[i], 2'b01}, {cap_a[0][1], cap_l[0]});
            if (n == 2) check_val("decode 2", {1'b1, pat[i][3], 1'b0}, {cap_a[1][1], cap_l[1][3:2]});
            check_val("halves", n, rd_q.size());
        end
    endtask
    // Fills from each quad; last is uncached code
    task automatic t_fill();
        logic [3:0] ea;
        for (int q = 0; q < 4; q++) begin
            clr();
            cacheable_in = (q != 3);
            send(32'h1000 + 4 * q, 4'h3, {2'b01, q == 3, 1'b0}, 32'h0);
            wait_done(1);
            check_val("fill length", 8, cap_a.size());
            check_val("first lanes", 0, cap_l[0][3:2]);
            for (int i = 0; i < 8; i++) begin
                ea = {q[1:0] ^ i[2:1], i[0], 1'b0};
                check_val("fill order", 32'h1000 + ea, cap_a[i]);
                check_val("fill data", {ea[3:1], 4'h0, ea | 4'h1, 4'h0, ea}, rd_q[i]);
            end
        end
        cacheable_in = 1'b0;
    endtask
    task automatic t_stop();
        clr();
        cacheable_in = 1'b1;
        send(32'h1800, 4'h0, 4'b0100, 32'h0);
        for (int i = 0; i < 200 && rd_q.size() < 2; i++) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        stop_fill_in = 1'b1;
        wait_done(1);
        stop_fill_in = 1'b0;
        cacheable_in = 1'b0;
        check_val("early end", 1, cap_a.size() > 2 && cap_a.size() < 5);
    endtask
    // Hold fills the queue; slow memory drains it
    task automatic t_hold_fifo();
        clr();
        hold_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check_val("hold grant", 1, hold_granted_out);
        for (int k = 0; k < 4; k++) send(32'h2000 + 4 * k, 4'hC, 4'b1100, k);
        check_val("full ready", 0, req_ready_out);
        check_val("held strobes", 0, strobes);
        mem_delay = 3;
        hold_in = 1'b0;
        wait_done(4);
        for (int k = 0; k < 4; k++) check_val("queued data", k, cap_d[k]);
        mem_delay = 0;
    endtask
    task automatic end_sim();
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        check_val("ready in reset", 1, req_ready_out);
        nrst_in = 1'b1;
        t_write();
        t_patterns();
        t_fill();
        t_stop();
        t_hold_fifo();
        check_val("parity errors", 0, perr);
        end_sim();
    end
endmodule // test_halfword_bus_burst_interface
`default_nettype wire
